// ==== logic/encoder_mode_tone_map.svh ====
// Constants for the encoder mode and tone field interpreter
// What this block does
// [R1] Mode word replaces configured encoder feature defaults
// [R2] Host ORs mode word with desired defaults
// [R3] Mode field: id 0x02, one 16-bit word
// [R4] 0x1840 enables detect, DTX, noise suppression
// [R5] Bit 14 is tone send enable
// [R6] Host zeroes reserved bits; bits 8,7 compand
// [R7] Host need not resend mode word each frame
// [R8] Tone field 0x08 forces one tone frame
// [R9] Host repeats tone field for longer tones
// [R10] Single tones 0x05 to 0x7A
// [R11] DTMF mapping chosen by rate index range
// [R12] One index code for generate and report
// [R13] Amplitude signed dBm0, +3 down to -90
// [R14] Tone generation only in packet mode
// [R15] Each channel packet yields one speech packet
// [R16] Speech packet layout follows format setting
// [R17] Speech packets accepted only in packet mode
// [R18] Mode word changes mode for that frame
// [R19] Unknown tone index starts no tone
`ifndef ENCODER_MODE_TONE_MAP_SVH
`define ENCODER_MODE_TONE_MAP_SVH
// Register byte offsets
`define OFS_CTRL 5'h00
`define OFS_DEFAULTS 5'h04
`define OFS_STATUS 5'h08
`define OFS_TONE 5'h0C
`define OFS_COUNT 5'h10
// Control register fields
`define CTRL_PKT_MODE_BIT 0
`define CTRL_RATE_LSB 8
`define CTRL_RATE_MSB 13
`define CTRL_SFMT_LSB 16
`define CTRL_SFMT_MSB 23
// Reset values
`define RST_CTRL 32'h0000_0001
`define RST_DEFAULTS 16'h0000
// Packet types and field identifiers
`define PKT_TYPE_CHAN 8'h01
`define PKT_TYPE_SPEECH 8'h02
`define FID_SPEECH_DATA 8'h00
`define FID_MODE 8'h02
`define FID_TONE 8'h08
`define FID_CHANNEL 8'h40
// Mode word bit positions
`define MB_TONE_SEND 14
`define MB_TONE_DETECT 12
`define MB_DTX 11
`define MB_COMPAND_EN 8
`define MB_COMPAND_SEL 7
`define MB_NOISE_SUPP 6
`define MODE_DEFINED_MASK 16'h59C0
// Tone index ranges
`define TONE_SINGLE_LO 8'h05
`define TONE_SINGLE_HI 8'h7A
`define TONE_DTMF_LO 8'h80
`define TONE_DTMF_HI 8'h8F
`define TONE_CALL_LO 8'hA0
`define TONE_CALL_HI 8'hA2
`define TONE_INACTIVE 8'hFF
`define RATE_SPLIT 6'h20
// Amplitude limits, signed dBm0
`define AMP_MAX 8'sh03
`define AMP_MIN 8'shA6
`endif

// ==== logic/encoder_mode_tone_pkg.sv ====
// Types shared by the encoder mode and tone field interpreter
package encoder_mode_tone_pkg;
  typedef enum logic [2:0] {
    TK_NONE, TK_SINGLE, TK_DTMF, TK_CALL, TK_INACTIVE, TK_INVALID
  } tone_kind_t;
  typedef enum logic [3:0] {
    PS_TYPE, PS_FID, PS_MODE_HI, PS_MODE_LO, PS_SOUND_CODE_INDEX, PS_TONE_AMP,
    PS_SP_COUNT, PS_SKIP_N, PS_SKIP_ALL
  } pstate_t;
  // Incoming packet byte stream
  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [7:0] data;
  } byte_in_t;
  // Encoder feature flags
  typedef struct packed {
    logic tone_send_enable;
    logic tone_detect_enable;
    logic discontinuous_tx_enable;
    logic compand_enable;
    logic compand_select;
    logic noise_suppress_enable;
  } features_t;
  // One encoder frame command
  typedef struct packed {
    features_t feat;
    logic [15:0] mode_word;
    logic tone_go;
    tone_kind_t kind;
    logic [7:0] sound_code_index;
    logic [3:0] digit;
    logic [7:0] amplitude;
  } frame_t;
  // Request for one output speech packet
  typedef struct packed {
    logic [7:0] speech_format_config_field;
  } speech_req_t;
endpackage

// ==== logic/tone_index_decoder.sv ====
// Classifies a tone index code and maps DTMF codes to digits
`timescale 1ns/1ps
`include "encoder_mode_tone_map.svh"
module tone_index_decoder (
  // Code to classify
  input wire logic [7:0] code,
  input wire logic rate_upper,
  // Classification
  output encoder_mode_tone_pkg::tone_kind_t kind,
  output logic [3:0] digit
);
  import encoder_mode_tone_pkg::*;
  // Digits 0-9, A-D as 10-13, star 14, hash 15
  function automatic logic [3:0] low_rate_digit(input logic [3:0] n);
    logic [3:0] d;
    d = 4'h0;
    case (n)
      4'h0: d = 4'h1;
      4'h4: d = 4'h2;
      4'h8: d = 4'h3;
      4'h1: d = 4'h4;
      4'h5: d = 4'h5;
      4'h9: d = 4'h6;
      4'h2: d = 4'h7;
      4'h6: d = 4'h8;
      4'hA: d = 4'h9;
      4'h7: d = 4'h0;
      4'hC: d = 4'hA;
      4'hD: d = 4'hB;
      4'hE: d = 4'hC;
      4'hF: d = 4'hD;
      4'h3: d = 4'hE;
      4'hB: d = 4'hF;
      default: d = 4'h0;
    endcase
    return d;
  endfunction
  // Range classification of the code
  always_comb begin
    kind = TK_INVALID;
    digit = 4'h0;
    // [R10] single tone range
    if (code >= `TONE_SINGLE_LO && code <= `TONE_SINGLE_HI) begin
      kind = TK_SINGLE;
    // [R11] DTMF table by rate
    end else if (code >= `TONE_DTMF_LO && code <= `TONE_DTMF_HI) begin
      kind = TK_DTMF;
      digit = rate_upper ? code[3:0] : low_rate_digit(code[3:0]);
    end else if (code >= `TONE_CALL_LO && code <= `TONE_CALL_HI) begin
      kind = TK_CALL;
    end else if (code == `TONE_INACTIVE) begin
      kind = TK_INACTIVE;
    end
  end
endmodule

// ==== logic/encoder_mode_tone_fields.sv ====
// Encoder mode and tone field interpreter with Avalon-MM registers
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "encoder_mode_tone_map.svh"
module encoder_mode_tone_fields (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Packet byte stream from the packet interface
  input encoder_mode_tone_pkg::byte_in_t pkt_in,
  // Encoder frame commands
  output logic frame_valid,
  output encoder_mode_tone_pkg::frame_t frame,
  // Output speech packet requests
  output logic speech_req_valid,
  output encoder_mode_tone_pkg::speech_req_t speech_req,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import encoder_mode_tone_pkg::*;

  // All block state
  typedef struct packed {
    pstate_t ps;
    logic [8:0] skip;
    logic tone_seen;
    logic mode_seen;
    logic in_speech;
    logic [7:0] mode_hi;
    logic [15:0] mode;
    logic [7:0] tidx;
    logic [7:0] tamp;
    logic [31:0] ctrl;
    logic [15:0] defaults;
    logic [15:0] cnt_chan;
    logic [15:0] cnt_speech;
    tone_kind_t last_kind;
    logic frame_v;
    frame_t frame;
    logic speech_v;
    speech_req_t speech;
    logic wait_r;
    logic [31:0] rdata;
  } st_t;

  st_t st_r;
  st_t st_nxt;
  tone_kind_t kind;
  logic [3:0] digit;
  logic rate_upper;
  logic in_pm;

  assign in_pm = st_r.ctrl[`CTRL_PKT_MODE_BIT];
  // [R11] rate index picks table
  assign rate_upper = st_r.ctrl[`CTRL_RATE_MSB:`CTRL_RATE_LSB] > `RATE_SPLIT;

  // [R12] shared index decoding
  tone_index_decoder u_dec (
    .code(st_r.tidx),
    .rate_upper(rate_upper),
    .kind(kind),
    .digit(digit)
  );

  // Merge written bytes into a register value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Feature flags from a mode word
  function automatic features_t decode_mode(input logic [15:0] m);
    features_t f;
    // [R5] tone send flag
    f.tone_send_enable = m[`MB_TONE_SEND];
    // [R4] detect, DTX, noise bits
    f.tone_detect_enable = m[`MB_TONE_DETECT];
    f.discontinuous_tx_enable = m[`MB_DTX];
    f.compand_enable = m[`MB_COMPAND_EN];
    f.compand_select = m[`MB_COMPAND_SEL];
    f.noise_suppress_enable = m[`MB_NOISE_SUPP];
    return f;
  endfunction

  // Packet parser, frame commit and register slave
  always_comb begin
    logic b_valid;
    logic b_last;
    logic [7:0] b;
    logic commit;
    logic [7:0] amp;
    logic [15:0] wmode;
    logic amp_ok;
    logic [31:0] wr;
    b_valid = pkt_in.valid;
    b_last = pkt_in.last;
    b = pkt_in.data;
    commit = 1'b0;
    amp = st_r.tamp;
    wmode = st_r.mode;
    amp_ok = 1'b0;
    wr = 32'h0000_0000;
    st_nxt = st_r;
    st_nxt.frame_v = 1'b0;
    st_nxt.speech_v = 1'b0;

    // Byte stream parsing
    if (b_valid) begin
      if (pkt_in.first) begin
        st_nxt.tone_seen = 1'b0;
        st_nxt.mode_seen = 1'b0;
        st_nxt.ps = PS_SKIP_ALL;
        // Refused packets never end in a frame
        st_nxt.in_speech = 1'b0;
        // [R17] speech packets only in packet mode
        if (b == `PKT_TYPE_SPEECH && in_pm) begin
          st_nxt.ps = PS_FID;
          st_nxt.in_speech = 1'b1;
        end
        // [R15] count channel packets in
        if (b == `PKT_TYPE_CHAN) begin
          st_nxt.cnt_chan = st_r.cnt_chan + 16'h0001;
          if (b_last) begin
            st_nxt.speech_v = 1'b1;
          end
        end
      end else begin
        case (st_r.ps)
          PS_FID: begin
            case (b)
              // [R3] mode field identifier
              `FID_MODE: st_nxt.ps = PS_MODE_HI;
              // [R8] tone field identifier
              `FID_TONE: st_nxt.ps = PS_SOUND_CODE_INDEX;
              `FID_SPEECH_DATA: st_nxt.ps = PS_SP_COUNT;
              `FID_CHANNEL: begin
                st_nxt.skip = 9'h001;
                st_nxt.ps = PS_SKIP_N;
              end
              default: st_nxt.ps = PS_SKIP_ALL;
            endcase
          end
          PS_MODE_HI: begin
            st_nxt.mode_hi = b;
            st_nxt.ps = PS_MODE_LO;
          end
          PS_MODE_LO: begin
            // [R3] high byte then low byte
            wmode = {st_r.mode_hi, b};
            // [R1] override replaces defaults
            st_nxt.mode = wmode & `MODE_DEFINED_MASK;
            st_nxt.mode_seen = 1'b1;
            st_nxt.ps = PS_FID;
          end
          PS_SOUND_CODE_INDEX: begin
            st_nxt.tidx = b;
            st_nxt.ps = PS_TONE_AMP;
          end
          PS_TONE_AMP: begin
            st_nxt.tamp = b;
            amp = b;
            st_nxt.tone_seen = 1'b1;
            st_nxt.ps = PS_FID;
          end
          PS_SP_COUNT: begin
            // Two bytes per sample follow
            st_nxt.skip = {b, 1'b0};
            st_nxt.ps = (b == 8'h00) ? PS_FID : PS_SKIP_N;
          end
          PS_SKIP_N: begin
            st_nxt.skip = st_r.skip - 9'h001;
            if (st_r.skip == 9'h001) begin
              st_nxt.ps = PS_FID;
            end
          end
          PS_SKIP_ALL: st_nxt.ps = PS_SKIP_ALL;
          default: st_nxt.ps = PS_SKIP_ALL;
        endcase
        // [R15] one speech packet per channel packet
        if (b_last && st_r.ps == PS_SKIP_ALL && st_r.skip == 9'h1FF) begin
          st_nxt.speech_v = 1'b1;
        end
      end
      // Frame ends at the last byte of an accepted speech packet
      if (b_last) begin
        if (pkt_in.first) begin
          commit = (b == `PKT_TYPE_SPEECH) && in_pm;
        end else begin
          commit = st_r.in_speech && st_r.ps != PS_TYPE;
        end
        // Partial fields at the end are dropped
        st_nxt.ps = PS_TYPE;
        // Stray tail bytes cannot commit
        st_nxt.in_speech = 1'b0;
      end
      // Mark channel packets so their end is recognised
      if (pkt_in.first) begin
        st_nxt.skip = (b == `PKT_TYPE_CHAN) ? 9'h1FF : 9'h000;
      end
    end

    // [R18] mode applies to this frame
    if (commit) begin
      // [R13] signed amplitude within +3..-90
      amp_ok = $signed(amp) <= `AMP_MAX && $signed(amp) >= `AMP_MIN;
      st_nxt.frame_v = 1'b1;
      st_nxt.frame.mode_word = st_nxt.mode;
      st_nxt.frame.feat = decode_mode(st_nxt.mode);
      st_nxt.frame.sound_code_index = st_nxt.tidx;
      st_nxt.frame.kind = st_nxt.tone_seen ? kind : TK_NONE;
      st_nxt.frame.digit = digit;
      st_nxt.frame.amplitude = amp;
      // [R14] tone only in packet mode
      // [R19] invalid or inactive index gives no tone
      st_nxt.frame.tone_go = st_nxt.tone_seen && in_pm && amp_ok
                             && st_nxt.mode[`MB_TONE_SEND]
                             && (kind == TK_SINGLE || kind == TK_DTMF
                                 || kind == TK_CALL);
      if (st_nxt.tone_seen) begin
        st_nxt.last_kind = kind;
      end
    end

    // [R16] speech packet uses format setting
    if (st_nxt.speech_v) begin
      st_nxt.speech.speech_format_config_field =
        st_r.ctrl[`CTRL_SFMT_MSB:`CTRL_SFMT_LSB];
      st_nxt.cnt_speech = st_r.cnt_speech + 16'h0001;
    end

    // Avalon slave, one wait state per access
    st_nxt.wait_r = 1'b1;
    if ((avs_read || avs_write) && st_r.wait_r) begin
      st_nxt.wait_r = 1'b0;
      st_nxt.rdata = 32'h0000_0000;
      if (avs_read) begin
        case (avs_address)
          `OFS_CTRL: st_nxt.rdata = st_r.ctrl;
          `OFS_DEFAULTS: st_nxt.rdata = {16'h0000, st_r.defaults};
          `OFS_STATUS: st_nxt.rdata = {5'h00, st_r.last_kind, st_r.tidx,
                                       st_r.mode};
          `OFS_TONE: st_nxt.rdata = {23'h000000, st_r.tone_seen, st_r.tamp};
          `OFS_COUNT: st_nxt.rdata = {st_r.cnt_speech, st_r.cnt_chan};
          default: st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
    // Writes take effect when waitrequest is low
    if (avs_write && !st_r.wait_r) begin
      case (avs_address)
        `OFS_CTRL: begin
          wr = merge(st_r.ctrl, avs_writedata, avs_byteenable);
          st_nxt.ctrl = {8'h00, wr[23:16], 2'b00, wr[13:8], 7'h00, wr[0]};
        end
        `OFS_DEFAULTS: begin
          wr = merge({16'h0000, st_r.defaults}, avs_writedata, avs_byteenable);
          st_nxt.defaults = wr[15:0] & `MODE_DEFINED_MASK;
          // [R1] configured defaults load the mode
          st_nxt.mode = wr[15:0] & `MODE_DEFINED_MASK;
        end
        default: st_nxt.ctrl = st_nxt.ctrl;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.ps <= PS_TYPE;
      st_r.ctrl <= `RST_CTRL;
      st_r.defaults <= `RST_DEFAULTS;
      st_r.mode <= `RST_DEFAULTS;
      st_r.last_kind <= TK_NONE;
      st_r.frame.kind <= TK_NONE;
      st_r.wait_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign frame_valid = st_r.frame_v;
  assign frame = st_r.frame;
  assign speech_req_valid = st_r.speech_v;
  assign speech_req = st_r.speech;
  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.wait_r;
endmodule

// ==== verif/mode_tone_chk.sv ====
// Concurrent checks on the ports of the encoder mode and tone interpreter
`timescale 1ns/1ps
module mode_tone_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Packet side
  input encoder_mode_tone_pkg::byte_in_t pkt_in,
  input wire logic frame_valid,
  input encoder_mode_tone_pkg::frame_t frame,
  input wire logic speech_req_valid,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  import encoder_mode_tone_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Output pulses follow a closing byte
  a_speech_cause: assert property (
    speech_req_valid |-> $past(pkt_in.valid && pkt_in.last)) else $error("speech req w/o last byte");
  a_frame_cause: assert property (
    frame_valid |-> $past(pkt_in.valid && pkt_in.last)) else $error("frame w/o last byte");
  // Mode word content
  a_mode_clean: assert property (
    frame_valid |-> (frame.mode_word & 16'hA63F) == 16'h0000) else $error("reserved mode bits kept");
  a_feat_decode: assert property (
    frame_valid |-> frame.feat == {frame.mode_word[14], frame.mode_word[12:11],
    frame.mode_word[8:6]}) else $error("feature flags differ from mode word");
  // Tone start conditions
  a_tone_gate: assert property (
    frame_valid && frame.tone_go |-> frame.feat.tone_send_enable
    && frame.kind inside {TK_SINGLE, TK_DTMF, TK_CALL} && $signed(frame.amplitude) >= -90
    && $signed(frame.amplitude) <= 3) else $error("tone started without cause");
  a_invalid_idle: assert property (
    frame_valid && frame.kind == TK_INVALID |-> !frame.tone_go) else $error("invalid tone started");
  a_single_range: assert property (
    frame_valid && frame.kind == TK_SINGLE |-> frame.sound_code_index inside {[8'h05:8'h7A]})
    else $error("single tone index out of range");
  // Frame holds between pulses
  a_frame_hold: assert property (
    !frame_valid |-> $stable(frame)) else $error("frame changed without pulse");
  // One wait state per access
  a_wait_state: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait state");
endmodule
bind encoder_mode_tone_fields mode_tone_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .pkt_in(pkt_in), .frame_valid(frame_valid), .frame(frame), .speech_req_valid(speech_req_valid),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

// ==== verif/host_pkt_model.sv ====
// Host model that feeds packet bytes into the block
`timescale 1ns/1ps
module host_pkt_model (
  // Clock
  input wire logic sys_clk,
  // Byte stream to the block
  output encoder_mode_tone_pkg::byte_in_t pkt_in
);
  import encoder_mode_tone_pkg::*;
  // Idle stream shows no stale byte
  initial pkt_in = {3'b000, 8'hFF};
  function automatic logic [15:0] mode_of(input logic [15:0] dflt, input logic [15:0] extra);
    mode_of = (dflt | extra) & 16'h59C0;
  endfunction
  // Whole packet, one byte per cycle
  task automatic send(input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++) begin
      @(posedge sys_clk);
      pkt_in <= {1'b1, i == 0, i == b.size() - 1, b[i]};
    end
    @(posedge sys_clk);
    pkt_in <= {3'b000, ~b[b.size() - 1]};
  endtask
endmodule

// ==== verif/encoder_mode_tone_fields_tb.sv ====
// Self-checking testbench for the encoder mode and tone interpreter
`timescale 1ns/1ps
module encoder_mode_tone_fields_tb;
  import encoder_mode_tone_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  byte_in_t pkt_in;
  frame_t frame, fr;
  speech_req_t speech_req, sp;
  logic frame_valid, speech_req_valid, avs_waitrequest;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rd;
  logic [15:0] mw;
  int fail_count = 0, num_checks = 0, n_fr = 0, n_sp = 0, e_fr = 0, e_sp = 0;
  // Clock at 20 MHz
  always #25 sys_clk = ~sys_clk;
  encoder_mode_tone_fields DUT (.sys_clk(sys_clk), .rst_n(rst_n), .pkt_in(pkt_in),
    .frame_valid(frame_valid), .frame(frame), .speech_req_valid(speech_req_valid),
    .speech_req(speech_req), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  host_pkt_model host (.sys_clk(sys_clk), .pkt_in(pkt_in));
  // Capture output pulses
  always @(posedge sys_clk) begin
    if (frame_valid === 1'b1) begin
      n_fr++;
      fr = frame;
    end
    if (speech_req_valid === 1'b1) begin
      n_sp++;
      sp = speech_req;
    end
  end
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Wait for the expected pulse counts
  task automatic wait_out();
    int k;
    k = 0;
    while ((n_fr < e_fr || n_sp < e_sp) && k < 20) begin
      @(posedge sys_clk);
      k++;
    end
    repeat (3) @(posedge sys_clk);
    check(n_fr, e_fr, "frames");
    check(n_sp, e_sp, "speech requests");
  endtask
  // Reset values, unmapped place, defaults as mode
  task automatic t_regs();
    bus(1'b0, 5'h00, 32'h0000_0000);
    check(rd, 32'h0000_0001, "ctrl reset");
    bus(1'b0, 5'h04, 32'h0000_0000);
    check(rd, 32'h0000_0000, "defaults reset");
    bus(1'b1, 5'h14, 32'hFFFF_FFFF);
    bus(1'b0, 5'h14, 32'h0000_0000);
    check(rd, 32'h0000_0000, "unmapped read");
    bus(1'b1, 5'h04, 32'h0000_1840);
    host.send('{8'h02, 8'h08, 8'h05, 8'h03});
    e_fr++;
    wait_out();
    check(fr.mode_word, 16'h1840, "defaults mode");
    check(fr.feat, 6'h19, "detect dtx ns flags");
    check(fr.tone_go, 1'b0, "tone without send bit");
    check(fr.kind, TK_SINGLE, "single kind");
  endtask
  // Mode and tone in one packet
  task automatic t_walk();
    mw = host.mode_of(16'h1840, 16'h4000);
    host.send('{8'h02, 8'h02, mw[15:8], mw[7:0], 8'h08, 8'h81, 8'hC4});
    e_fr++;
    wait_out();
    check(fr.mode_word, 16'h5840, "tone send mode");
    check(fr.feat, 6'h39, "flags with send");
    check(fr.tone_go, 1'b1, "tone frame");
    check(fr.kind, TK_DTMF, "dtmf kind");
    check(fr.digit, 4'h4, "lower table digit");
    check(fr.sound_code_index, 8'h81, "index kept");
    check(fr.amplitude, 8'hC4, "amplitude");
  endtask
  // Raw override with reserved bits, then tone table
  task automatic t_override();
    logic [7:0] ix [9] = '{8'h05, 8'h7A, 8'h04, 8'hA2, 8'hA3, 8'hFF, 8'h80, 8'h8B, 8'h8B};
    logic [7:0] am [9] = '{8'hA6, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA5, 8'h04, 8'h00};
    tone_kind_t kd [9] = '{TK_SINGLE, TK_SINGLE, TK_INVALID, TK_CALL, TK_INVALID, TK_INACTIVE,
      TK_DTMF, TK_DTMF, TK_DTMF};
    logic go [9] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    host.send('{8'h02, 8'h02, 8'hFF, 8'hFF});
    e_fr++;
    wait_out();
    check(fr.mode_word, 16'h59C0, "override clears reserved");
    check(fr.kind, TK_NONE, "no tone field");
    for (int i = 0; i < 9; i++) begin
      host.send('{8'h02, 8'h08, ix[i], am[i]}); // mode word not resent
      e_fr++;
      wait_out();
      check(fr.mode_word, 16'h59C0, "mode kept");
      check(fr.kind, kd[i], "tone kind");
      check(fr.tone_go, go[i], "tone start");
    end
    check(fr.digit, 4'hF, "lower hash digit");
  endtask
  // Packet mode off refuses speech packets
  task automatic t_mode_off();
    bus(1'b1, 5'h00, 32'h0000_0000);
    host.send('{8'h02, 8'h08, 8'h05, 8'h03});
    wait_out();
    bus(1'b1, 5'h00, 32'h005A_2101);
  endtask
  // Upper DTMF table at rate index 33
  task automatic t_upper();
    logic [7:0] ix [3] = '{8'h81, 8'h80, 8'h8F};
    logic [3:0] dg [3] = '{4'h1, 4'h0, 4'hF};
    for (int i = 0; i < 3; i++) begin
      host.send('{8'h02, 8'h08, ix[i], 8'h00});
      e_fr++;
      wait_out();
      check(fr.digit, dg[i], "upper table digit");
      check(fr.tone_go, 1'b1, "tone in packet mode");
    end
  endtask
  // Channel packets with one idle cycle between, speech data skipped
  task automatic t_channel();
    host.send('{8'h01, 8'h40, 8'h00});
    host.send('{8'h01});
    host.send('{8'h02, 8'h00, 8'h01, 8'h12, 8'h34, 8'h08, 8'h05, 8'h03});
    e_sp += 2;
    e_fr++;
    wait_out();
    check(sp.speech_format_config_field, 8'h5A, "speech format");
    check(fr.kind, TK_SINGLE, "tone after speech data");
    bus(1'b0, 5'h10, 32'h0000_0000);
    check(rd, 32'h0002_0002, "packet counts");
  endtask
  // Counts and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_walk();
    t_override();
    t_mode_off();
    t_upper();
    t_channel();
    summarize();
  end
  // Watchdog
  initial begin
    repeat (6000) @(posedge sys_clk);
    fail_count++;
    summarize();
  end
endmodule
